// [common/lbhs_pkg.sv]
// Package for the local bus hold and cycle status block.
// Assumes a single 100 MHz clock domain and no software registers.
package lbhs_pkg;

   // Cycle type codes on the three status lines (bit2 bit1 bit0)
   localparam logic [2:0] LBHS_ST_INTA    = 3'h0;
   localparam logic [2:0] LBHS_ST_IO_RD   = 3'h1;
   localparam logic [2:0] LBHS_ST_IO_WR   = 3'h2;
   localparam logic [2:0] LBHS_ST_HALT    = 3'h3;
   localparam logic [2:0] LBHS_ST_CODE    = 3'h4;
   localparam logic [2:0] LBHS_ST_MEM_RD  = 3'h5;
   localparam logic [2:0] LBHS_ST_MEM_WR  = 3'h6;
   localparam logic [2:0] LBHS_ST_PASSIVE = 3'h7;

   // Field positions inside a status code
   localparam int LBHS_BIT_DIR = 1;
   localparam int LBHS_BIT_MIO = 2;

   // Reset values
   localparam logic LBHS_GRANT_RST = 1'b0;
   localparam logic LBHS_FLOAT_RST = 1'b0;

   // Bus clock states
   typedef enum logic [2:0] {
      LBHS_TI, LBHS_T1, LBHS_T2, LBHS_T3, LBHS_TW, LBHS_T4
   } lbhs_tstate_t;

   // Cycle request from the execution side
   typedef struct packed {
      logic       valid;
      logic [2:0] kind;
   } lbhs_cyc_req_t;

   // Pin group driven toward the local bus
   typedef struct packed {
      logic [2:0] status;    // Status line values
      logic [2:0] status_oe_n; // Low while driving
      logic       mio;
      logic       dir;
      logic       ctl_oe_n;  // Bus and control lines driven when low
   } lbhs_pins_t;

endpackage

// [verilog/lbhs_grant.sv]
// Hold request / grant handshake for minimum mode.
// Assumes the request input is already synchronous to clk_i.
`timescale 1ns/100ps
module lbhs_grant
   import lbhs_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Bus state
   input  wire logic at_boundary_i,  // In t4 or idle
   input  wire logic need_cycle_i,   // A cycle is about to start
   // Request side
   input  wire logic hold_req_i,
   // Results
   output logic      grant_o,
   output logic      float_o
);

   logic grant_q;
   logic float_q;

   // Grant: rises only at a cycle boundary, falls when request drops
   // [RULE2] grant at boundary
   // [RULE4] release on low request
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         grant_q <= LBHS_GRANT_RST;
      end else if (grant_q) begin
         grant_q <= hold_req_i;
      end else if (hold_req_i && at_boundary_i) begin
         grant_q <= 1'b1;
      end
   end

   // Float: set with the grant, kept until the next own cycle
   // [RULE3] float with grant
   // [RULE5] float until next cycle
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         float_q <= LBHS_FLOAT_RST;
      end else if (!grant_q && hold_req_i && at_boundary_i) begin
         float_q <= 1'b1;
      end else if (!grant_q && need_cycle_i) begin
         float_q <= 1'b0;
      end
   end

   assign grant_o = grant_q;
   assign float_o = float_q | grant_q;

   // [RULE3] float covers grant
   grant_float_a: assert property ( // [RULE3]
      @(posedge clk_i) disable iff (!rstn_i)
      grant_o |-> float_o)
      else $error("grant without float");

   // [RULE2] grant only at boundary
   grant_rise_a: assert property ( // [RULE2]
      @(posedge clk_i) disable iff (!rstn_i)
      $rose(grant_q) |-> $past(at_boundary_i) && $past(hold_req_i))
      else $error("grant rose outside t4 or idle");

   // [RULE4] grant drops after request low
   grant_fall_a: assert property ( // [RULE4]
      @(posedge clk_i) disable iff (!rstn_i)
      grant_q && !hold_req_i |=> !grant_q)
      else $error("grant held after request low");

endmodule

// [verilog/lbhs_top.sv]
// Local bus hold handshake and cycle status sequencer.
// Assumes the execution side raises cyc_req for one cycle type at a
// time and holds it until cyc_start_o; all inputs are synchronous.
// Operation
// [RULE1] Requester holds request high while wanting bus
// [RULE2] Grant rises only in t4 or idle
// [RULE3] Bus floats together with grant
// [RULE4] Grant falls after request sampled low
// [RULE5] Stay floating until next own cycle
// [RULE6] Request input treated as synchronous
// [RULE7] Valid status in t4, t1, t2; the code shows it in t1 and t2 only
// [RULE8] Passive status in t3 or ready wait
// [RULE9] Status leaving passive in t4 starts cycle; the code leaves passive at the start of t1
// [RULE10] Three-bit low-active cycle type encoding
// [RULE11] Status lines floated during grant
// [RULE12] Mode pin picks minimum or maximum
// [RULE13] Memory/IO and direction mirror status bits
// [RULE14] Running transfer finishes before grant
`timescale 1ns/100ps
module lbhs_top
   import lbhs_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rstn_i,
   // Mode and bus handshake
   input  wire logic          interface_mode_select_i, // High: minimum
   input  wire logic          hold_req_i,
   input  wire logic          ready_i,
   // Execution side
   input  wire lbhs_cyc_req_t cyc_req_i,
   output logic               cyc_start_o,
   output logic               cyc_done_o,
   // Minimum mode pins
   output logic               bus_grant_out_o,
   output logic               mio_o,
   output logic               transfer_direction_line_o,
   output logic               ctl_oe_n_o,
   // Maximum mode status pins
   output logic               cycle_status_bit0_o,
   output logic               cycle_status_bit1_o,
   output logic               cycle_status_bit2_o,
   output logic [2:0]         status_oe_n_o,
   // Bundled pin view
   output lbhs_pins_t         pins_o
);

   lbhs_tstate_t tstate_q;
   logic [2:0]   code_q;
   logic [2:0]   status_q;
   logic         min_mode;
   logic         grant;
   logic         floating;
   logic         at_boundary;
   logic         start;
   logic         hold_block;

   // [RULE12] mode pin selects interface
   assign min_mode = interface_mode_select_i;

   // [RULE14] boundary only in t4 or idle
   assign at_boundary = (tstate_q == LBHS_T4) || (tstate_q == LBHS_TI);

   // A minimum mode request pending or granted keeps new cycles from starting
   // [RULE6] request sampled directly
   assign hold_block = grant || (hold_req_i && min_mode && at_boundary);
   assign start = cyc_req_i.valid && at_boundary && !hold_block;

   // Handshake lives in its own module so the hold logic can be reused
   lbhs_grant u_grant (
      .clk_i        (clk_i),
      .rstn_i       (rstn_i),
      .at_boundary_i(at_boundary && min_mode),
      .need_cycle_i (cyc_req_i.valid && at_boundary),
      .hold_req_i   (hold_req_i && min_mode),
      .grant_o      (grant),
      .float_o      (floating)
   );

   // T-state sequencer; wait states until ready is high in t3
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tstate_q <= LBHS_TI;
      end else begin
         case (tstate_q)
            LBHS_TI: tstate_q <= start ? LBHS_T1 : LBHS_TI;
            LBHS_T1: tstate_q <= LBHS_T2;
            LBHS_T2: tstate_q <= LBHS_T3;
            LBHS_T3: tstate_q <= ready_i ? LBHS_T4 : LBHS_TW;
            LBHS_TW: tstate_q <= ready_i ? LBHS_T4 : LBHS_TW;
            LBHS_T4: tstate_q <= start ? LBHS_T1 : LBHS_TI;
            default: tstate_q <= LBHS_TI;
         endcase
      end
   end

   // Latch the cycle type when a cycle is launched
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         code_q <= LBHS_ST_PASSIVE;
      end else if (start) begin
         code_q <= cyc_req_i.kind;
      end
   end

   // Status: code in t1 and t2 after launch; passive from t3 on
   // [RULE7] status valid t1 t2, not in t4
   // [RULE8] passive in t3 or ready wait
   // [RULE9] leaving passive marks start
   // [RULE10] code taken from cycle type
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_q <= LBHS_ST_PASSIVE;
      end else if (start) begin
         status_q <= cyc_req_i.kind;
      end else if (tstate_q == LBHS_T1 || tstate_q == LBHS_T2) begin
         status_q <= (tstate_q == LBHS_T2) ? LBHS_ST_PASSIVE : code_q;
      end else begin
         status_q <= LBHS_ST_PASSIVE;
      end
   end

   assign cyc_start_o = start;
   assign cyc_done_o  = (tstate_q == LBHS_T4);
   assign bus_grant_out_o = grant;

   // [RULE11] status floats during grant, reads as ones
   // [RULE13] mio and direction mirror status bits
   assign cycle_status_bit0_o = floating ? 1'b1 : status_q[0];
   assign cycle_status_bit1_o = floating ? 1'b1 : status_q[LBHS_BIT_DIR];
   assign cycle_status_bit2_o = floating ? 1'b1 : status_q[LBHS_BIT_MIO];
   assign status_oe_n_o = {3{floating || min_mode}};
   assign mio_o = floating ? 1'b1 : code_q[LBHS_BIT_MIO];
   assign transfer_direction_line_o =
      floating ? 1'b1 : code_q[LBHS_BIT_DIR];
   // [RULE3] control lines float with grant
   assign ctl_oe_n_o = floating;

   assign pins_o = '{status     : {cycle_status_bit2_o,
                                    cycle_status_bit1_o,
                                    cycle_status_bit0_o},
                     status_oe_n: status_oe_n_o,
                     mio        : mio_o,
                     dir        : transfer_direction_line_o,
                     ctl_oe_n   : ctl_oe_n_o};

   // [RULE8] passive two cycles after t1 start
   status_end_a: assert property ( // [RULE8]
      @(posedge clk_i) disable iff (!rstn_i)
      tstate_q == LBHS_T2 |=> status_q == LBHS_ST_PASSIVE)
      else $error("status not passive in t3");

   // [RULE7] code stands in t1
   status_t1_a: assert property ( // [RULE7]
      @(posedge clk_i) disable iff (!rstn_i)
      tstate_q == LBHS_T1 |-> status_q == code_q)
      else $error("status not valid in t1");

   // [RULE7] code still stands in t2
   status_t2_a: assert property ( // [RULE7]
      @(posedge clk_i) disable iff (!rstn_i)
      tstate_q == LBHS_T2 |-> status_q == code_q)
      else $error("status not valid in t2");

   // [RULE8] passive through t3 and waits
   status_pass_a: assert property ( // [RULE8]
      @(posedge clk_i) disable iff (!rstn_i)
      tstate_q == LBHS_T3 || tstate_q == LBHS_TW |-> status_q == 3'h7)
      else $error("status not passive in t3 or wait");

   // [RULE8] ready ends the transfer
   ready_end_a: assert property ( // [RULE8]
      @(posedge clk_i) disable iff (!rstn_i)
      (tstate_q == LBHS_T3 || tstate_q == LBHS_TW) && ready_i
         |=> tstate_q == LBHS_T4)
      else $error("ready did not lead to t4");

   // [RULE9] launch shows new code
   launch_code_a: assert property ( // [RULE9]
      @(posedge clk_i) disable iff (!rstn_i)
      cyc_start_o |=> tstate_q == LBHS_T1
         && status_q == $past(cyc_req_i.kind))
      else $error("launched code not shown in t1");

   // [RULE14] no grant inside a transfer
   grant_idle_a: assert property ( // [RULE14]
      @(posedge clk_i) disable iff (!rstn_i)
      $rose(grant) |-> $past(at_boundary))
      else $error("grant during active transfer");

   // [RULE3] control lines float while granted
   ctl_float_a: assert property ( // [RULE3]
      @(posedge clk_i) disable iff (!rstn_i)
      bus_grant_out_o |-> ctl_oe_n_o)
      else $error("control lines driven during grant");

   // [RULE11] status floated while granted
   status_float_a: assert property ( // [RULE11]
      @(posedge clk_i) disable iff (!rstn_i)
      grant |-> status_oe_n_o == 3'h7 && pins_o.status == 3'h7)
      else $error("status driven during grant");

   // [RULE5] no own cycle while granted
   no_cycle_a: assert property ( // [RULE5]
      @(posedge clk_i) disable iff (!rstn_i)
      grant |-> !cyc_start_o)
      else $error("cycle started while granted");

   // [RULE5] still floating after release
   float_keep_a: assert property ( // [RULE5]
      @(posedge clk_i) disable iff (!rstn_i)
      $fell(grant) |-> ctl_oe_n_o)
      else $error("bus driven again at grant release");

   // [RULE5] own cycle drives bus again
   float_end_a: assert property ( // [RULE5]
      @(posedge clk_i) disable iff (!rstn_i)
      cyc_start_o |=> !ctl_oe_n_o)
      else $error("bus still floating in own cycle");

   // [RULE12] maximum mode drives status
   max_drive_a: assert property ( // [RULE12]
      @(posedge clk_i) disable iff (!rstn_i)
      !min_mode && !floating |-> status_oe_n_o == 3'h0)
      else $error("status not driven in maximum mode");

   // [RULE12] no grant in maximum mode
   max_grant_a: assert property ( // [RULE12]
      @(posedge clk_i) disable iff (!rstn_i)
      !$past(min_mode) |-> !grant)
      else $error("grant raised in maximum mode");

endmodule

// [sim/lbhs_far_model.sv]
// Far side model: a second bus master and a ready source.
// Assumes one clock shared with the device and bench control inputs.
`timescale 1ns/100ps
module lbhs_far_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // Bench control
   input  wire logic       want_i,
   input  wire logic [1:0] waits_i,
   input  wire logic       start_i,
   // Toward the device
   output logic            hold_req_o,
   output logic            ready_o
);
   logic [2:0] cnt_q;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) hold_req_o <= 1'b0;
      else hold_req_o <= want_i;
   end

   // Cycle age; saturates so ready idles high
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) cnt_q <= 3'h7;
      else if (start_i) cnt_q <= 3'h0;
      else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
   end

   // Ready from t3 on, later by the wait count
   assign ready_o = (cnt_q >= {1'b0, waits_i} + 3'h2);
endmodule

// [sim/local_bus_hold_and_status_tb.sv]
// Self-checking bench for the hold handshake and cycle status.
// Assumes the far side model in lbhs_far_model.sv.
`timescale 1ns/100ps
module local_bus_hold_and_status_tb;
   import lbhs_pkg::*;
   logic          clk, rstn, mode, want, hold, ready, start, done;
   logic          grant, mio, dir, ctl_oe_n, s0, s1, s2;
   logic [1:0]    waits;
   logic [2:0]    st_oe_n;
   lbhs_cyc_req_t req;
   lbhs_pins_t    pins;
   int            n_errors, n_tests;

   lbhs_top i_dut (.clk_i(clk), .rstn_i(rstn),
      .interface_mode_select_i(mode), .hold_req_i(hold), .ready_i(ready),
      .cyc_req_i(req), .cyc_start_o(start), .cyc_done_o(done),
      .bus_grant_out_o(grant), .mio_o(mio),
      .transfer_direction_line_o(dir), .ctl_oe_n_o(ctl_oe_n),
      .cycle_status_bit0_o(s0), .cycle_status_bit1_o(s1),
      .cycle_status_bit2_o(s2), .status_oe_n_o(st_oe_n), .pins_o(pins));
   lbhs_far_model i_far (.clk_i(clk), .rstn_i(rstn), .want_i(want),
      .waits_i(waits), .start_i(start), .hold_req_o(hold),
      .ready_o(ready));

   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Bounded wait on falling edges so flags are settled
   task automatic wait_for(ref logic f, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && f !== v; i++) @(negedge clk);
      if (f !== v) begin
         n_errors++;
         wrap_up();
      end
   endtask

   // One bus cycle, checked state by state
   task automatic run_cycle(input logic [2:0] kind);
      @(posedge clk);
      req <= '{valid: 1'b1, kind: kind};
      @(negedge clk);
      wait_for(start, 1'b1, 20);
      @(posedge clk);
      req.valid <= 1'b0;
      @(negedge clk);
      if (mode) chk({ctl_oe_n, mio, dir}, {1'b0, kind[2:1]});
      else chk({s2, s1, s0}, kind);
      if (!mode) chk(st_oe_n, 3'h0);
      if (!mode) chk(pins.status, kind);
      @(negedge clk);
      if (!mode) chk({s2, s1, s0}, kind);
      @(negedge clk);
      if (!mode) chk({s2, s1, s0}, LBHS_ST_PASSIVE);
      wait_for(done, 1'b1, 10);
      if (!mode) chk({s2, s1, s0}, LBHS_ST_PASSIVE);
   endtask

   // Maximum mode: every code except passive, varied waits, request ignored
   task automatic scen_status();
      mode <= 1'b0;
      want <= 1'b1;
      for (int k = 0; k < 7; k++) begin
         waits <= 2'(k % 3);
         run_cycle(3'(k));
         chk({2'h0, grant}, 3'h0);
      end
      want <= 1'b0;
   endtask

   // Minimum mode: request mid transfer, release, reclaim
   task automatic scen_hold();
      @(posedge clk);
      mode <= 1'b1;
      waits <= 2'h1;
      @(posedge clk);
      req <= '{valid: 1'b1, kind: LBHS_ST_MEM_RD};
      @(negedge clk);
      wait_for(start, 1'b1, 20);
      @(posedge clk);
      req.valid <= 1'b0;
      want <= 1'b1;
      repeat (3) begin
         @(negedge clk);
         chk({2'h0, grant}, 3'h0);
      end
      wait_for(done, 1'b1, 10);
      @(negedge clk);
      chk({grant, ctl_oe_n, mio}, 3'h7);
      chk({st_oe_n[0], dir, 1'b0}, 3'h6);
      chk(pins.status, 3'h7);
      @(posedge clk);
      want <= 1'b0;
      @(negedge clk);
      wait_for(grant, 1'b0, 4);
      repeat (3) @(negedge clk);
      chk({2'h0, ctl_oe_n}, 3'h1);
      run_cycle(LBHS_ST_IO_WR);
      // Request while idle is granted two edges later
      @(posedge clk);
      want <= 1'b1;
      repeat (2) @(negedge clk);
      chk({2'h0, grant}, 3'h0);
      @(negedge clk);
      chk({2'h0, grant}, 3'h1);
      want <= 1'b0;
   endtask

   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      mode = 1'b0;
      want = 1'b0;
      waits = 2'h0;
      req = '0;
      n_errors = 0;
      n_tests = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      scen_status();
      scen_hold();
      repeat (4) @(posedge clk);
      wrap_up();
   end
endmodule
